// [scasq_top.sv]
// Smart card activation sequencer: power-on hold, presence debounce,
// status output and the power-up / power-down sequences of the card.
// Assumes all inputs are synchronous to clk; analog blocks sit outside.
//
// Functional notes
// - Hold power-on alarm 16 ms after supply good, then sleep.
// - Stay asleep until activation request falls.
// - In standby all card contacts low, host lines pulled up.
// - Card present when high-presence is high or low-presence is low.
// - New presence must persist 8 ms debounce before acceptance.
// - Insertion while asleep raises status after debounce.
// - Card present at power-up: status after reset release plus debounce.
// - Status low on alarm or off, high when operable.
// - Activation falling edge starts rising sequence only if status high.
// - Charge pump starts on the activation falling edge.
// - Card reset input ignored until 300 ns after translators on.
// - Once effective, card clock starts when reset input is low.
// - If reset input already high, clock starts with reset release.
// - Request rising or internal alarm starts falling sequence.
// - Supply select low gives 3 V card supply, high gives 5 V.
// - Card reset output follows input; 200 us ignore after re-activation.
// - Alarm from supply faults, logic undervoltage, heat, pump, removal.
// - Alarm clears only with card present, faults gone, request high.
`timescale 1ns/1ps
`default_nettype none
module scasq_top #(
	parameter logic [31:0] POR_CYCLES = 32'(scasq_pkg::POR_CYC),
	parameter logic [31:0] DEBOUNCE_CYCLES = 32'(scasq_pkg::DEBOUNCE_CYC),
	parameter logic [31:0] RENEW_CYCLES = 32'(scasq_pkg::RENEW_IGNORE_CYC),
	parameter logic [31:0] IGNORE_CYCLES = 32'(scasq_pkg::RESET_IGNORE_CYC),
	parameter logic [31:0] STEP_CYCLES = 32'(scasq_pkg::STEP_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic logic_supply_ok,
	input wire logic card_present_high,
	input wire logic card_present_low,
	input wire logic activate_request_n,
	input wire logic card_reset_in,
	input wire logic supply_select,
	input wire logic card_supply_fault,
	input wire logic card_overcurrent,
	input wire logic over_temperature,
	input wire logic pump_output_low,
	output logic fault_status_n,
	output logic pump_enable,
	output logic card_supply_on,
	output logic card_supply_5v,
	output logic line_translator_on,
	output logic host_pullup_on,
	output logic card_lines_low,
	output logic card_reset_out,
	output logic card_clock_on
);

	// Zero counts would leave a timer expired from the start
	if (POR_CYCLES == 32'h0 || DEBOUNCE_CYCLES == 32'h0 ||
		IGNORE_CYCLES == 32'h0 || STEP_CYCLES == 32'h0 ||
		RENEW_CYCLES == 32'h0) begin : g_count_check
		$error("timing counts must be at least one cycle");
	end

	// -----------------------------------------------------------------
	// Supervision: power-on hold, presence and alarm
	// -----------------------------------------------------------------
	scasq_pkg::scasq_state_type state_reg, state_next;
	logic req_prev_reg;
	logic alarm_reg, alarm_next;
	logic renewed_reg;
	logic por_expired, deb_expired, seq_expired;
	wire presence_raw = card_present_high | ~card_present_low;
	wire por_active = ~por_expired;
	wire req_fall = req_prev_reg & ~activate_request_n;
	wire req_rise = ~req_prev_reg & activate_request_n;

	// Supply must stay good for the whole hold time
	scasq_timer #(
		.WIDTH(scasq_pkg::TIMER_WIDTH),
		.INIT(POR_CYCLES)
	) u_por_timer (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(~logic_supply_ok),
		.value(POR_CYCLES),
		.expired(por_expired)
	);

	// Debounce restarts whenever presence drops or power-on hold is active
	scasq_timer #(
		.WIDTH(scasq_pkg::TIMER_WIDTH),
		.INIT(DEBOUNCE_CYCLES)
	) u_deb_timer (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(~presence_raw | por_active),
		.value(DEBOUNCE_CYCLES),
		.expired(deb_expired)
	);

	wire present_ok = presence_raw & deb_expired & ~por_active;
	// Removal counts at once; only insertion is debounced
	wire fault_now = card_supply_fault | card_overcurrent |
		over_temperature | pump_output_low | ~logic_supply_ok |
		~presence_raw;
	// Set wins over clear since the fault terms are ORed in first
	wire alarm_clear = present_ok & ~fault_now & activate_request_n;
	assign alarm_next = por_active | fault_now |
		(alarm_reg & ~alarm_clear);

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			scasq_pkg::ST_POR: begin
				if (por_expired)
					state_next = scasq_pkg::ST_SLEEP;
			end
			scasq_pkg::ST_SLEEP: begin
				if (por_active)
					state_next = scasq_pkg::ST_POR;
				else if (req_fall && !alarm_reg)
					state_next = scasq_pkg::ST_PUMP;
			end
			scasq_pkg::ST_PUMP: begin
				if (alarm_reg || req_rise)
					state_next = scasq_pkg::ST_F_SUPPLY;
				else if (seq_expired)
					state_next = scasq_pkg::ST_SUPPLY;
			end
			scasq_pkg::ST_SUPPLY: begin
				if (alarm_reg || req_rise)
					state_next = scasq_pkg::ST_F_SUPPLY;
				else if (seq_expired)
					state_next = scasq_pkg::ST_ACTIVE;
			end
			scasq_pkg::ST_ACTIVE: begin
				if (alarm_reg || req_rise)
					state_next = scasq_pkg::ST_F_RST;
			end
			scasq_pkg::ST_F_RST: begin
				if (seq_expired)
					state_next = scasq_pkg::ST_F_CLK;
			end
			scasq_pkg::ST_F_CLK: begin
				if (seq_expired)
					state_next = scasq_pkg::ST_F_LINES;
			end
			scasq_pkg::ST_F_LINES: begin
				if (seq_expired)
					state_next = scasq_pkg::ST_F_SUPPLY;
			end
			scasq_pkg::ST_F_SUPPLY: begin
				if (seq_expired)
					state_next = scasq_pkg::ST_SLEEP;
			end
			default: state_next = scasq_pkg::ST_POR;
		endcase
	end

	// Each state change reloads the step timer; in the active state it
	// times the window during which the card reset input is ignored
	wire seq_load = (state_next != state_reg);
	wire [31:0] ignore_value = renewed_reg ? RENEW_CYCLES :
		IGNORE_CYCLES;
	wire [31:0] seq_value = (state_next == scasq_pkg::ST_ACTIVE) ?
		ignore_value : STEP_CYCLES;

	scasq_timer #(
		.WIDTH(scasq_pkg::TIMER_WIDTH),
		.INIT(32'h0)
	) u_seq_timer (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(seq_load),
		.value(seq_value),
		.expired(seq_expired)
	);

	// -----------------------------------------------------------------
	// Output decode
	// -----------------------------------------------------------------
	wire reset_effective = (state_reg == scasq_pkg::ST_ACTIVE) &
		(state_next == scasq_pkg::ST_ACTIVE) & seq_expired & ~seq_load;
	wire in_standby = (state_next == scasq_pkg::ST_POR) |
		(state_next == scasq_pkg::ST_SLEEP);
	// The supply-off step already has pump and supply down, so an abort
	// from the pump step never switches the card supply on
	wire pump_next = ~in_standby &
		(state_next != scasq_pkg::ST_F_SUPPLY);
	wire supply_next = pump_next &
		(state_next != scasq_pkg::ST_PUMP);
	wire xlate_next = (state_next == scasq_pkg::ST_ACTIVE) |
		(state_next == scasq_pkg::ST_F_RST) |
		(state_next == scasq_pkg::ST_F_CLK);
	// Reset out mirrors the input; clock comes with effectiveness, so a
	// high input releases reset and starts the clock in the same cycle
	wire rst_out_next = reset_effective & card_reset_in;
	wire clk_on_next = reset_effective |
		(card_clock_on & (state_next == scasq_pkg::ST_F_RST));
	wire renewed_next = renewed_reg |
		(state_reg == scasq_pkg::ST_ACTIVE);

	// -----------------------------------------------------------------
	// State registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= scasq_pkg::ST_POR;
			req_prev_reg <= 1'b1;
			alarm_reg <= 1'b1;
			renewed_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			req_prev_reg <= activate_request_n;
			alarm_reg <= alarm_next;
			renewed_reg <= renewed_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_status_n <= 1'b0;
			pump_enable <= 1'b0;
			card_supply_on <= 1'b0;
			card_supply_5v <= 1'b0;
			line_translator_on <= 1'b0;
			host_pullup_on <= 1'b1;
			card_lines_low <= 1'b1;
			card_reset_out <= 1'b0;
			card_clock_on <= 1'b0;
		end else if (clk_en) begin
			fault_status_n <= ~alarm_next;
			pump_enable <= pump_next;
			card_supply_on <= supply_next;
			card_supply_5v <= supply_select;
			line_translator_on <= xlate_next;
			host_pullup_on <= ~xlate_next;
			card_lines_low <= ~xlate_next;
			card_reset_out <= rst_out_next;
			card_clock_on <= clk_on_next;
		end
	end

endmodule
`default_nettype wire

// [scasq_pkg.sv]
// Constants shared by the card activation sequencer and its timer.
// Assumes a single 125 MHz clock; all times are converted to cycles here.
package scasq_pkg;

	// -----------------------------------------------------------------
	// Clock and times
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int POR_TIME_MS = 16;
	localparam int DEBOUNCE_TIME_MS = 8;
	localparam int RESET_IGNORE_NS = 300;
	localparam int RENEW_IGNORE_US = 200;
	localparam int STEP_TIME_NS = 1000;

	// Reset-ignore and step times round up, the others divide evenly; all at least one cycle
	localparam int POR_CYC = (POR_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int DEBOUNCE_CYC =
		(DEBOUNCE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int RESET_IGNORE_CYC =
		(RESET_IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RENEW_IGNORE_CYC = (RENEW_IGNORE_US * 1000) / CLK_PERIOD_NS;
	localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_WIDTH = 32;

	// -----------------------------------------------------------------
	// Sequencer states, Gray along power-up and power-down path except the aborts to supply-off and the return from supply-off to sleep
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_POR = 4'h0,
		ST_SLEEP = 4'h1,
		ST_PUMP = 4'h3,
		ST_SUPPLY = 4'h2,
		ST_ACTIVE = 4'h6,
		ST_F_RST = 4'h7,
		ST_F_CLK = 4'h5,
		ST_F_LINES = 4'h4,
		ST_F_SUPPLY = 4'hC
	} scasq_state_type;

endpackage

// [scasq_timer.sv]
// Loadable down-counter with an expiry flag.
// Assumes load and enable are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module scasq_timer #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	output logic expired
);

	logic [WIDTH-1:0] count_reg;

	// Checked while elaborating, so a bad width never reaches a run
	if (WIDTH < 2) begin : g_width_check
		$error("timer width too small");
	end

	assign expired = (count_reg == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= INIT;
		else if (clk_en) begin
			if (load)
				count_reg <= value;
			else if (!expired)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule
`default_nettype wire

// [scasq_card_model.sv]
// Card side of the sequencer: presence contacts of an inserted card.
// Assumes the bench decides when a card sits in the slot.
`timescale 1ns/1ps
`default_nettype none
module scasq_card_model (
	input wire logic inserted,
	input wire logic style,
	output logic card_present_high,
	output logic card_present_low
);
	// Style picks which contact the card closes; the other idles at its pull
	assign card_present_high = inserted & ~style;
	assign card_present_low = ~(inserted & style);
endmodule
`default_nettype wire

// [scasq_chk_chk.sv]
// Port checker for scasq_top, bound from the bench top file.
// Assumes clk_en held high and the shortened bench timer settings.
`timescale 1ns/1ps
`default_nettype none
module scasq_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic logic_supply_ok,
	input wire logic card_present_high,
	input wire logic card_present_low,
	input wire logic activate_request_n,
	input wire logic card_reset_in,
	input wire logic card_supply_fault,
	input wire logic card_overcurrent,
	input wire logic over_temperature,
	input wire logic pump_output_low,
	input wire logic fault_status_n,
	input wire logic pump_enable,
	input wire logic card_supply_on,
	input wire logic line_translator_on,
	input wire logic card_reset_out,
	input wire logic card_clock_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire flt = card_supply_fault | card_overcurrent | over_temperature
		| pump_output_low | !logic_supply_ok;
	wire act = card_clock_on & !activate_request_n & fault_status_n;
	// Request held low with no alarm: the sequencer is not aborting
	wire go = !activate_request_n & fault_status_n;
	// One sequencer step of three cycles plus the state change
	sequence off4_s(s);
		(!s)[*4];
	endsequence
	sequence go4_s;
		go[*4];
	endsequence
	sequence fall_s;
		!card_reset_out ##[1:5] (!card_clock_on && line_translator_on)
		##[1:5] (!line_translator_on && card_supply_on)
		##[1:5] (!card_supply_on && !pump_enable);
	endsequence
	AST_ACT_PUMP: assert property ($fell(activate_request_n) && fault_status_n
		&& !pump_enable && $past(pump_enable, 6) == 1'b0 |=> pump_enable)
		else $error("pump not started by activation");
	AST_REFUSE: assert property ($fell(activate_request_n) && !fault_status_n
		&& !pump_enable |=> !pump_enable)
		else $error("activation taken with status low");
	AST_SUPPLY_STEP: assert property ($rose(pump_enable) |-> off4_s(card_supply_on))
		else $error("card supply came up too early");
	AST_SUPPLY_RISE: assert property ($rose(pump_enable) ##0 go4_s
		|=> card_supply_on)
		else $error("card supply step timing wrong");
	AST_TRANS_STEP: assert property ($rose(card_supply_on)
		|-> off4_s(line_translator_on))
		else $error("translator came up too early");
	AST_TRANS_RISE: assert property ($rose(card_supply_on) ##0 go4_s
		|=> line_translator_on)
		else $error("translator step timing wrong");
	AST_IDLE_LOW: assert property (!card_supply_on |-> !line_translator_on
		&& !card_clock_on && !card_reset_out)
		else $error("card contacts active without supply");
	AST_RST_IGNORE: assert property ($rose(line_translator_on)
		|-> (!card_clock_on)[*8])
		else $error("card clock started too early");
	AST_FOLLOW: assert property (act ##1 act
		|-> card_reset_out == $past(card_reset_in))
		else $error("card reset output not following input");
	AST_FALL_ORDER: assert property (card_clock_on && $rose(activate_request_n)
		|=> fall_s)
		else $error("falling sequence order wrong");
	AST_FAULT: assert property (flt |=> !fault_status_n)
		else $error("fault did not lower status");
	AST_REMOVED: assert property (!card_present_high && card_present_low
		|=> !fault_status_n)
		else $error("missing card did not lower status");
endmodule
`default_nettype wire

// [scasq_tb_top.sv]
// Self-checking bench for scasq_top with a card model in the slot.
// Assumes shortened timers: hold 20, debounce 10, renew 8, step 3.
`timescale 1ns/1ps
`default_nettype none
module smart_card_activation_sequencer_tb_top;
	localparam int POR = 20;
	localparam int DEB = 10;
	logic clk = 1'b0, rst_n = 1'b0, logic_supply_ok = 1'b1;
	logic activate_request_n = 1'b1, card_reset_in = 1'b0;
	logic supply_select = 1'b0, inserted = 1'b1, style = 1'b0;
	logic [3:0] flt = 4'h0;
	logic card_present_high, card_present_low, fault_status_n, pump_enable;
	logic card_supply_on, card_supply_5v, line_translator_on, host_pullup_on;
	logic card_lines_low, card_reset_out, card_clock_on;
	int num_errors = 0, checked = 0, n;
	scasq_card_model card (.inserted, .style, .card_present_high,
		.card_present_low);
	scasq_top #(.POR_CYCLES(32'h14), .DEBOUNCE_CYCLES(32'hA),
		.RENEW_CYCLES(32'h8), .STEP_CYCLES(32'h3)) dut (.clk, .rst_n,
		.clk_en(1'b1), .logic_supply_ok, .card_present_high,
		.card_present_low, .activate_request_n, .card_reset_in,
		.supply_select, .card_supply_fault(flt[0]),
		.card_overcurrent(flt[1]), .over_temperature(flt[2]),
		.pump_output_low(flt[3]), .fault_status_n, .pump_enable,
		.card_supply_on, .card_supply_5v, .line_translator_on,
		.host_pullup_on, .card_lines_low, .card_reset_out, .card_clock_on);
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic e, input logic s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, s);
		end
	endtask
	// Bounded so a stuck output ends in a mismatch, not a hang
	task automatic wait_for(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 200) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial forever #4 clk = ~clk;
	initial begin
		#100000;
		num_errors++;
		give_verdict;
	end
	initial begin
		cyc(3);
		rst_n = 1'b1;
		wait_for(fault_status_n, 1'b1, n);
		chk("power_on_hold", 1'b1, n >= POR + DEB && n <= POR + DEB + 4);
		chk("idle_lines_low", 1'b1, card_lines_low);
		chk("idle_pullup", 1'b1, host_pullup_on);
		supply_select = 1'b1;
		card_reset_in = 1'b1;
		cyc(1);
		activate_request_n = 1'b0;
		wait_for(card_clock_on, 1'b1, n);
		chk("first_ignore", 1'b1, n >= 47 && n <= 49);
		chk("clock_with_release", 1'b1, card_reset_out);
		chk("supply_5v", 1'b1, card_supply_5v);
		chk("active_pullup_off", 1'b0, host_pullup_on);
		chk("active_lines_free", 1'b0, card_lines_low);
		for (int i = 0; i < 2; i++) begin
			card_reset_in = i[0];
			cyc(2);
			chk("reset_follow", i[0], card_reset_out);
		end
		activate_request_n = 1'b1;
		wait_for(card_supply_on, 1'b0, n);
		chk("fall_on_release", 1'b1, n <= 20 && !pump_enable);
		supply_select = 1'b0;
		card_reset_in = 1'b0;
		cyc(6);
		activate_request_n = 1'b0;
		wait_for(card_clock_on, 1'b1, n);
		chk("renew_ignore", 1'b1, n >= 17 && n <= 19);
		chk("clock_before_release", 1'b0, card_reset_out);
		chk("supply_3v", 1'b0, card_supply_5v);
		inserted = 1'b0;
		cyc(2);
		chk("removal_alarm", 1'b0, fault_status_n);
		wait_for(card_supply_on, 1'b0, n);
		chk("fall_on_alarm", 1'b1, n <= 20);
		style = 1'b1;
		inserted = 1'b1;
		cyc(DEB + 4);
		chk("held_by_request", 1'b0, fault_status_n);
		activate_request_n = 1'b1;
		wait_for(fault_status_n, 1'b1, n);
		chk("clear_on_request", 1'b1, n <= 2);
		inserted = 1'b0;
		cyc(2);
		activate_request_n = 1'b0;
		cyc(3);
		chk("refused_pump", 1'b0, pump_enable);
		activate_request_n = 1'b1;
		inserted = 1'b1;
		cyc(DEB - 3);
		inserted = 1'b0;
		cyc(2);
		chk("glitch_ignored", 1'b0, fault_status_n);
		inserted = 1'b1;
		wait_for(fault_status_n, 1'b1, n);
		chk("debounce", 1'b1, n >= DEB && n <= DEB + 2);
		for (int i = 0; i < 4; i++) begin
			flt[i] = 1'b1;
			cyc(2);
			chk("fault_alarm", 1'b0, fault_status_n);
			flt = 4'h0;
			wait_for(fault_status_n, 1'b1, n);
			chk("fault_clear", 1'b1, n <= 3);
		end
		// Request withdrawn during the pump step aborts before supply
		activate_request_n = 1'b0;
		cyc(2);
		chk("abort_pump_on", 1'b1, pump_enable);
		activate_request_n = 1'b1;
		cyc(2);
		chk("abort_pump_off", 1'b0, pump_enable);
		chk("abort_no_supply", 1'b0, card_supply_on);
		logic_supply_ok = 1'b0;
		cyc(2);
		chk("supply_alarm", 1'b0, fault_status_n);
		logic_supply_ok = 1'b1;
		wait_for(fault_status_n, 1'b1, n);
		chk("hold_restart", 1'b1, n >= POR + DEB && n <= POR + DEB + 2);
		give_verdict;
	end
endmodule
bind scasq_top scasq_chk chk (.clk, .rst_n, .logic_supply_ok,
	.card_present_high, .card_present_low, .activate_request_n,
	.card_reset_in, .card_supply_fault, .card_overcurrent, .over_temperature,
	.pump_output_low, .fault_status_n, .pump_enable, .card_supply_on,
	.line_translator_on, .card_reset_out, .card_clock_on);
`default_nettype wire
